// ===== rtl/ssi_pkg.sv
// Constants for the serial interface status and interrupt logic
package ssi_pkg;
  // ==========================================
  // Register offsets
  localparam logic [7:0] OFS_CONTROL   = 8'h00;
  localparam logic [7:0] OFS_MODE      = 8'h04;
  localparam logic [7:0] OFS_RX_HOLD   = 8'h08;
  localparam logic [7:0] OFS_TX_HOLD   = 8'h0c;
  localparam logic [7:0] OFS_STATUS    = 8'h10;
  localparam logic [7:0] OFS_IRQ_SET   = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLEAR = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1c;
  // ==========================================
  // Control and transmit fields
  localparam int BIT_ENABLE_CMD  = 0;
  localparam int BIT_DISABLE_CMD = 1;
  localparam int BIT_LAST_XFER   = 24;
  localparam int SEL_LSB         = 16;
  localparam int DATA_W          = 16;
  // ==========================================
  // Mode fields
  localparam int BIT_VAR_SELECT = 1;
  localparam int BIT_CS_HOLD    = 3;
  localparam int DELAY_LSB      = 24;
  localparam logic [31:0] MODE_MASK = 32'hff0f_000a;
  // ==========================================
  // Status flag positions
  localparam int FLAG_RX_FULL    = 0;
  localparam int FLAG_TX_HOLD_E  = 1;
  localparam int FLAG_MODE_FAULT = 2;
  localparam int FLAG_OVERRUN    = 3;
  localparam int FLAG_END_RX     = 4;
  localparam int FLAG_END_TX     = 5;
  localparam int FLAG_RX_BUFF    = 6;
  localparam int FLAG_TX_BUFE    = 7;
  localparam int FLAG_SS_RISE    = 8;
  localparam int FLAG_ALL_EMPTY  = 9;
  localparam int FLAG_ENABLED    = 16;
  localparam int NUM_SOURCES     = 10;
  // ==========================================
  // Reset values
  localparam logic [3:0]  CS_IDLE    = 4'hf;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
endpackage

// ===== rtl/ssi_status_irq.sv
// Status flags, interrupt mask and chip-select release of the serial interface
// Notes on behaviour
// [RL1] Last-transfer bit honoured only in variable select
// [RL2] Last-transfer releases chip select after character
// [RL3] Receive full set on load, cleared on read
// [RL4] Holding empty low while data waits
// [RL5] Holding empty zero at reset/disable, enable sets
// [RL6] Mode fault set on fault, status read clears
// [RL7] Overrun on second load without read
// [RL8] End of receive after counter hits zero
// [RL9] End of transmit after counter hits zero
// [RL10] Receive buffer full when both counters zero
// [RL11] Transmit buffer empty when both counters zero
// [RL12] Slave-select rise flag, status read clears
// [RL13] All-empty clears on write, sets after delay
// [RL14] Status bit 16 shows enabled state
// [RL15] Enable register ones enable sources
// [RL16] Disable register ones disable sources
// [RL17] Mask view shows enabled sources, bit 9 too
// [RL18] DMA counters are inputs from DMA controller
// [RL19] Enable and disable together means disabled
// [RL20] Hold keeps chip select until other select
// [RL21] Interrupt high when flag and mask both set
// [RL22] Unused bits read zero, writes ignored
`timescale 1ns/1ps
module ssi_status_irq #(
  parameter int CNT_W = 16
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic      [31:0]       rdata,
  input  wire logic              shifter_take,
  input  wire logic              shift_done,
  input  wire logic              shifter_busy,
  input  wire logic              rx_load,
  input  wire logic [15:0]       rx_data,
  input  wire logic              mode_fault_event,
  input  wire logic              slave_select_input,
  input  wire logic [CNT_W-1:0]  dma_receive_counter,
  input  wire logic [CNT_W-1:0]  dma_receive_next_counter,
  input  wire logic [CNT_W-1:0]  dma_transmit_counter,
  input  wire logic [CNT_W-1:0]  dma_transmit_next_counter,
  input  wire logic              dma_rx_count_write,
  input  wire logic              dma_tx_count_write,
  output logic      [15:0]       tx_data,
  output logic                   tx_pending,
  output logic      [3:0]        chip_select_lines,
  output logic                   enabled,
  output logic                   irq
);
  // ==========================================
  // Register decode
  wire logic wr_ctrl  = wr && addr == ssi_pkg::OFS_CONTROL;
  wire logic wr_mode  = wr && addr == ssi_pkg::OFS_MODE;
  wire logic wr_tx    = wr && addr == ssi_pkg::OFS_TX_HOLD;
  wire logic wr_iset  = wr && addr == ssi_pkg::OFS_IRQ_SET;
  wire logic wr_iclr  = wr && addr == ssi_pkg::OFS_IRQ_CLEAR;
  wire logic rd_rx    = rd && addr == ssi_pkg::OFS_RX_HOLD;
  wire logic rd_stat  = rd && addr == ssi_pkg::OFS_STATUS;
  wire logic en_cmd   = wr_ctrl && wdata[ssi_pkg::BIT_ENABLE_CMD];
  wire logic dis_cmd  = wr_ctrl && wdata[ssi_pkg::BIT_DISABLE_CMD];

  logic [31:0] mode;
  logic [15:0] rx_hold;
  logic [ssi_pkg::NUM_SOURCES-1:0] mask;
  logic        rx_full, tx_hold_empty, mode_fault, overrun;
  logic        end_rx, end_tx, ss_rise, all_empty;
  logic        ss_meta, ss_sync, ss_prev;
  logic        tx_last, fly_last;
  logic [3:0]  tx_sel;
  logic [7:0]  delay_cnt;

  wire logic       var_sel  = mode[ssi_pkg::BIT_VAR_SELECT];
  wire logic       cs_hold  = mode[ssi_pkg::BIT_CS_HOLD];
  wire logic [7:0] delay_cfg = mode[ssi_pkg::DELAY_LSB +: 8];
  wire logic [3:0] fix_sel  = mode[ssi_pkg::SEL_LSB +: 4];

  // ==========================================
  // Control commands
  wire logic next_enabled = dis_cmd ? 1'b0 : (en_cmd ? 1'b1 : enabled); // see [RL19]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      enabled <= 1'b0;
      mode    <= ssi_pkg::ZERO_WORD;
    end else begin
      enabled <= next_enabled; // see [RL14]
      if (wr_mode) begin
        mode <= wdata & ssi_pkg::MODE_MASK;
      end
    end
  end

  // ==========================================
  // Transmit holding register
  wire logic tx_accept = wr_tx && enabled;
  wire logic next_last = wdata[ssi_pkg::BIT_LAST_XFER] && var_sel; // see [RL1]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_hold_empty <= 1'b0;
      tx_pending    <= 1'b0;
      tx_data       <= 16'h0000;
      tx_last       <= 1'b0;
      tx_sel        <= 4'h0;
    end else begin
      if (!next_enabled) begin
        tx_hold_empty <= 1'b0; // see [RL5]
        tx_pending    <= 1'b0;
      end else if (tx_accept) begin
        tx_hold_empty <= 1'b0; // see [RL4]
        tx_pending    <= 1'b1;
        tx_data       <= wdata[ssi_pkg::DATA_W-1:0];
        tx_last       <= next_last;
        tx_sel        <= var_sel ? wdata[ssi_pkg::SEL_LSB +: 4] : fix_sel;
      end else if (shifter_take || en_cmd) begin
        tx_hold_empty <= 1'b1; // see [RL4] [RL5]
        tx_pending    <= 1'b0;
      end
    end
  end

  // ==========================================
  // Chip select handling
  function automatic logic [3:0] sel_decode(input logic [3:0] s);
    if (!s[0]) begin
      sel_decode = 4'he;
    end else if (!s[1]) begin
      sel_decode = 4'hd;
    end else if (!s[2]) begin
      sel_decode = 4'hb;
    end else if (!s[3]) begin
      sel_decode = 4'h7;
    end else begin
      sel_decode = ssi_pkg::CS_IDLE;
    end
  endfunction

  wire logic release_cs = shift_done && (fly_last || !cs_hold); // see [RL2] [RL20]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chip_select_lines <= ssi_pkg::CS_IDLE;
      fly_last          <= 1'b0;
    end else begin
      if (!enabled) begin
        chip_select_lines <= ssi_pkg::CS_IDLE;
        fly_last          <= 1'b0;
      end else if (shifter_take && tx_pending) begin
        chip_select_lines <= sel_decode(tx_sel); // see [RL20]
        fly_last          <= tx_last;
      end else if (release_cs) begin
        chip_select_lines <= ssi_pkg::CS_IDLE; // see [RL2]
        fly_last          <= 1'b0;
      end
    end
  end

  // ==========================================
  // Receive side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx_hold <= 16'h0000;
      rx_full <= 1'b0;
      overrun <= 1'b0;
    end else begin
      if (rx_load) begin
        rx_hold <= rx_data;
      end
      rx_full <= rx_load || (rx_full && !rd_rx); // see [RL3]
      overrun <= (rx_load && rx_full && !rd_rx) || (overrun && !rd_stat); // see [RL7]
    end
  end

  // ==========================================
  // Fault and slave-select flags
  wire logic ss_edge = ss_sync && !ss_prev;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ss_meta    <= 1'b1; // Pin idles high, no false edge
      ss_sync    <= 1'b1;
      ss_prev    <= 1'b1;
      mode_fault <= 1'b0;
      ss_rise    <= 1'b0;
    end else begin
      ss_meta    <= slave_select_input;
      ss_sync    <= ss_meta;
      ss_prev    <= ss_sync;
      mode_fault <= mode_fault_event || (mode_fault && !rd_stat); // see [RL6]
      ss_rise    <= ss_edge || (ss_rise && !rd_stat); // see [RL12]
    end
  end

  // ==========================================
  // DMA counter flags
  wire logic rx_cnt_zero  = dma_receive_counter == '0; // see [RL18]
  wire logic tx_cnt_zero  = dma_transmit_counter == '0;
  wire logic rx_buff_full = rx_cnt_zero && dma_receive_next_counter == '0; // see [RL10]
  wire logic tx_buf_empty = tx_cnt_zero && dma_transmit_next_counter == '0; // see [RL11]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      end_rx <= 1'b0;
      end_tx <= 1'b0;
    end else begin
      end_rx <= !dma_rx_count_write && (end_rx || rx_cnt_zero); // see [RL8]
      end_tx <= !dma_tx_count_write && (end_tx || tx_cnt_zero); // see [RL9]
    end
  end

  // ==========================================
  // Transmission registers empty
  wire logic idle_now = !tx_pending && !shifter_busy && delay_cnt == 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      delay_cnt <= 8'h00;
      all_empty <= 1'b0;
    end else begin
      if (shift_done) begin
        delay_cnt <= delay_cfg;
      end else if (delay_cnt != 8'h00) begin
        delay_cnt <= delay_cnt - 8'h01;
      end
      if (tx_accept) begin
        all_empty <= 1'b0; // see [RL13]
      end else if (enabled && idle_now && !shift_done) begin
        all_empty <= 1'b1; // see [RL13]
      end
    end
  end

  // ==========================================
  // Status word and interrupt mask
  wire logic [ssi_pkg::NUM_SOURCES-1:0] flags = {all_empty, ss_rise, tx_buf_empty, rx_buff_full,
                                                  end_tx, end_rx, overrun, mode_fault,
                                                  tx_hold_empty, rx_full};
  wire logic [31:0] status_word = {15'h0000, enabled, 6'h00, flags}; // see [RL14] [RL22]
  wire logic [31:0] mask_word   = {22'h00_0000, mask}; // see [RL17] [RL22]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mask <= '0;
      irq  <= 1'b0;
    end else begin
      mask <= (mask | (wr_iset ? wdata[ssi_pkg::NUM_SOURCES-1:0] : '0)) // see [RL15]
              & ~(wr_iclr ? wdata[ssi_pkg::NUM_SOURCES-1:0] : '0); // see [RL16]
      irq  <= |(flags & mask); // see [RL21]
    end
  end

  // ==========================================
  // Read data
  wire logic [31:0] next_rdata =
      !rd                          ? ssi_pkg::ZERO_WORD :
      addr == ssi_pkg::OFS_MODE    ? mode :
      addr == ssi_pkg::OFS_RX_HOLD ? {16'h0000, rx_hold} :
      addr == ssi_pkg::OFS_STATUS  ? status_word :
      addr == ssi_pkg::OFS_IRQ_MASK ? mask_word : ssi_pkg::ZERO_WORD; // see [RL22]

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata <= ssi_pkg::ZERO_WORD;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ==========================================
  // Checks
  both_cmds_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL19]
    (en_cmd && dis_cmd) |=> !enabled)
    else $error("enable and disable together left block enabled");

  rx_full_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL3]
    rx_load |=> rx_full)
    else $error("receive full not set after load");

  hold_dis_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL5]
    !enabled |-> !tx_hold_empty)
    else $error("holding empty set while disabled");

  overrun_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL7]
    (rx_load && rx_full && !rd_rx) |=> overrun)
    else $error("overrun missed");

  ss_rise_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL12]
    $rose(slave_select_input) ##2 1'b1 |=> ##[0:1] ss_rise)
    else $error("slave select rise not flagged");

  mask_set_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL15]
    (wr_iset && wdata[ssi_pkg::FLAG_ALL_EMPTY] && !wr_iclr) |=> mask[ssi_pkg::FLAG_ALL_EMPTY])
    else $error("enable write did not set mask");

  irq_level_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL21]
    |(flags & mask) |=> irq)
    else $error("interrupt not raised for masked flag");

  cs_release_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL2]
    (enabled && shift_done && fly_last && !shifter_take) |=> chip_select_lines == ssi_pkg::CS_IDLE)
    else $error("chip select not released after last transfer");

  empty_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL13]
    tx_accept |=> !all_empty ##1 !all_empty)
    else $error("all-empty flag not cleared by write");

  stat_read_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL6]
    (rd_stat && !mode_fault_event) |=> !mode_fault)
    else $error("mode fault not cleared by status read");

  hold_enable_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL5]
    (en_cmd && !dis_cmd) |=> tx_hold_empty)
    else $error("enable command did not set holding empty");

  hold_write_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL4]
    tx_accept |=> (!tx_hold_empty && tx_pending))
    else $error("holding empty not cleared by transmit write");

  hold_take_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL4]
    (shifter_take && enabled && !wr_ctrl && !wr_tx) |=> tx_hold_empty)
    else $error("holding empty not set after take");

  last_fixed_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL1]
    (tx_accept && !var_sel) |=> !tx_last)
    else $error("last-transfer kept under fixed select");

  last_var_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL1]
    (tx_accept && var_sel && wdata[ssi_pkg::BIT_LAST_XFER]) |=> tx_last)
    else $error("last-transfer lost under variable select");

  cs_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL20]
    (enabled && shift_done && cs_hold && !fly_last && !shifter_take) |=> $stable(chip_select_lines))
    else $error("chip select dropped while held");

  cs_disabled_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL2]
    !enabled |=> chip_select_lines == ssi_pkg::CS_IDLE)
    else $error("chip select active while disabled");

  rx_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL3]
    (rd_rx && !rx_load) |=> !rx_full)
    else $error("receive full not cleared by read");

  overrun_clr_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL7]
    (rd_stat && !(rx_load && rx_full)) |=> !overrun)
    else $error("overrun not cleared by status read");

  ss_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL12]
    (rd_stat && !ss_edge) |=> !ss_rise)
    else $error("slave select rise not cleared by status read");

  end_rx_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL8]
    dma_rx_count_write |=> !end_rx)
    else $error("end of receive not cleared by counter write");

  end_tx_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL9]
    (!dma_tx_count_write && tx_cnt_zero) |=> end_tx)
    else $error("end of transmit not set at zero count");

  enabled_read_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL14]
    rd_stat |=> rdata[ssi_pkg::FLAG_ENABLED] == $past(enabled))
    else $error("status read shows wrong enabled state");

  unused_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL22]
    rd_stat |=> (rdata[31:17] == 15'h0000 && rdata[15:10] == 6'h00))
    else $error("unused status bits not zero");

  mask_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL16]
    (wr_iclr && wdata[ssi_pkg::FLAG_SS_RISE]) |=> !mask[ssi_pkg::FLAG_SS_RISE])
    else $error("disable write did not clear mask");

  irq_low_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL21]
    !(|(flags & mask)) |=> !irq)
    else $error("interrupt raised with no masked flag");

  rdata_idle_a: assert property (@(posedge ref_clk) disable iff (rst) // see [RL22]
    !rd |=> rdata == ssi_pkg::ZERO_WORD)
    else $error("read data not zero outside read");
endmodule

// ===== test/ssi_shift_model.sv
// Behavioural shift engine facing the status logic
`timescale 1ns/1ps
module ssi_shift_model #(
  parameter int WAIT_CYC = 4,
  parameter int LEN      = 6
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic tx_pending,
  output logic      shifter_take,
  output logic      shift_done,
  output logic      shifter_busy
);
  int   cnt;
  logic active;
  // ==========================================
  // Take held data after a wait, shift for a while
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      active <= 1'b0;
      shifter_take <= 1'b0;
      shift_done <= 1'b0;
    end else begin
      shifter_take <= 1'b0;
      shift_done <= 1'b0;
      if (!active && tx_pending) begin
        cnt <= (cnt == WAIT_CYC) ? 0 : cnt + 1;
        active <= (cnt == WAIT_CYC);
        shifter_take <= (cnt == WAIT_CYC);
      end else if (active) begin
        cnt <= (cnt == LEN) ? 0 : cnt + 1;
        active <= (cnt != LEN);
        shift_done <= (cnt == LEN);
      end
    end
  end
  assign shifter_busy = active;
endmodule

// ===== test/testbench.sv
// Self-checking bench for the status and interrupt logic
`timescale 1ns/1ps
module testbench;
  logic        ref_clk, rst, wr, rd, rx_load, mode_fault_event, slave_select_input;
  logic        dma_rx_count_write, dma_tx_count_write, shifter_take, shift_done, shifter_busy;
  logic        tx_pending, enabled, irq;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata, st;
  logic [15:0] rx_data, tx_data, rcnt, rncnt, tcnt, tncnt;
  logic [3:0]  chip_select_lines;
  int          err_count, compares;

  ssi_status_irq #(.CNT_W(16)) ssi_status_irq_inst (.ref_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .shifter_take, .shift_done, .shifter_busy, .rx_load, .rx_data, .mode_fault_event, .slave_select_input,
    .dma_receive_counter(rcnt), .dma_receive_next_counter(rncnt), .dma_transmit_counter(tcnt),
    .dma_transmit_next_counter(tncnt), .dma_rx_count_write, .dma_tx_count_write, .tx_data, .tx_pending,
    .chip_select_lines, .enabled, .irq);
  ssi_shift_model ssi_shift_model_inst (.ref_clk, .rst, .tx_pending, .shifter_take, .shift_done, .shifter_busy);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 st = rdata;
  endtask
  task automatic wait_cs(input logic [3:0] v);
    for (int i = 0; i < 50 && chip_select_lines !== v; i++) @(posedge ref_clk);
    #1 chk(chip_select_lines, v);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[ssi_pkg::FLAG_TX_HOLD_E], 1'b0);
    chk(st[31:17], 15'h0000);
    chk(st[ssi_pkg::FLAG_SS_RISE], 1'b0);
    rd_reg(ssi_pkg::OFS_IRQ_MASK);
    chk(st, 32'h0000_0000);
    rd_reg(8'h40);
    chk(st, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_enable;
    wr_reg(ssi_pkg::OFS_CONTROL, 32'h0000_0001);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk({st[ssi_pkg::FLAG_ENABLED], st[ssi_pkg::FLAG_TX_HOLD_E]}, 2'h3);
    wr_reg(ssi_pkg::OFS_CONTROL, 32'h0000_0003);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk({st[ssi_pkg::FLAG_ENABLED], st[ssi_pkg::FLAG_TX_HOLD_E], enabled}, 3'h0);
    wr_reg(ssi_pkg::OFS_CONTROL, 32'h0000_0001);
    $display("enable test done");
  endtask
  task automatic t_tx;
    wr_reg(ssi_pkg::OFS_MODE, 32'h0000_000a);
    wr_reg(ssi_pkg::OFS_TX_HOLD, 32'h000e_00a5);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk({st[ssi_pkg::FLAG_ALL_EMPTY], st[ssi_pkg::FLAG_TX_HOLD_E]}, 2'h0);
    chk(tx_pending, 1'b1);
    wait_cs(4'he);
    chk(tx_data, 16'h00a5);
    chk(tx_pending, 1'b0);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[ssi_pkg::FLAG_TX_HOLD_E], 1'b1);
    repeat (14) @(posedge ref_clk);
    chk(chip_select_lines, 4'he);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[ssi_pkg::FLAG_ALL_EMPTY], 1'b1);
    wr_reg(ssi_pkg::OFS_TX_HOLD, 32'h010e_005a);
    wait_cs(4'hf);
    wr_reg(ssi_pkg::OFS_MODE, 32'h000e_0008);
    wr_reg(ssi_pkg::OFS_TX_HOLD, 32'h0100_0033);
    wait_cs(4'he);
    repeat (14) @(posedge ref_clk);
    chk(chip_select_lines, 4'he);
    $display("transmit test done");
  endtask
  task automatic t_rx;
    rx_data <= 16'h1234;
    repeat (2) begin
      @(posedge ref_clk);
      rx_load <= 1'b1;
      @(posedge ref_clk);
      rx_load <= 1'b0;
      rd_reg(ssi_pkg::OFS_STATUS);
      chk(st[ssi_pkg::FLAG_RX_FULL], 1'b1);
    end
    chk(st[ssi_pkg::FLAG_OVERRUN], 1'b1);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk({st[ssi_pkg::FLAG_OVERRUN], st[ssi_pkg::FLAG_RX_FULL]}, 2'h1);
    rd_reg(ssi_pkg::OFS_RX_HOLD);
    chk(st[15:0], 16'h1234);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[ssi_pkg::FLAG_RX_FULL], 1'b0);
    $display("receive test done");
  endtask
  task automatic t_events;
    @(posedge ref_clk);
    mode_fault_event <= 1'b1;
    slave_select_input <= 1'b0;
    @(posedge ref_clk);
    mode_fault_event <= 1'b0;
    repeat (4) @(posedge ref_clk);
    slave_select_input <= 1'b1;
    repeat (6) @(posedge ref_clk);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk({st[ssi_pkg::FLAG_SS_RISE], st[ssi_pkg::FLAG_MODE_FAULT]}, 2'h3);
    rd_reg(ssi_pkg::OFS_STATUS);
    chk({st[ssi_pkg::FLAG_SS_RISE], st[ssi_pkg::FLAG_MODE_FAULT]}, 2'h0);
    $display("event test done");
  endtask
  task automatic t_dma;
    @(posedge ref_clk);
    dma_rx_count_write <= 1'b1;
    dma_tx_count_write <= 1'b1;
    @(posedge ref_clk);
    dma_rx_count_write <= 1'b0;
    dma_tx_count_write <= 1'b0;
    rcnt <= 16'h0000;
    tcnt <= 16'h0000;
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[7:4], 4'h3);
    rncnt <= 16'h0000;
    tncnt <= 16'h0000;
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[7:4], 4'hf);
    rcnt <= 16'h0003;
    tcnt <= 16'h0003;
    dma_rx_count_write <= 1'b1;
    dma_tx_count_write <= 1'b1;
    @(posedge ref_clk);
    dma_rx_count_write <= 1'b0;
    dma_tx_count_write <= 1'b0;
    rd_reg(ssi_pkg::OFS_STATUS);
    chk(st[7:4], 4'h0);
    $display("buffer counter test done");
  endtask
  task automatic t_irq;
    wr_reg(ssi_pkg::OFS_IRQ_SET, 32'hffff_ffff);
    rd_reg(ssi_pkg::OFS_IRQ_MASK);
    chk(st, 32'h0000_03ff);
    chk(irq, 1'b1);
    wr_reg(ssi_pkg::OFS_IRQ_CLEAR, 32'h0000_03fd);
    wr_reg(ssi_pkg::OFS_IRQ_SET, 32'h0000_0000);
    wr_reg(ssi_pkg::OFS_IRQ_CLEAR, 32'h0000_0000);
    rd_reg(ssi_pkg::OFS_IRQ_MASK);
    chk(st, 32'h0000_0002);
    chk(irq, 1'b1);
    wr_reg(ssi_pkg::OFS_IRQ_CLEAR, 32'h0000_0002);
    repeat (3) @(posedge ref_clk);
    chk(irq, 1'b0);
    $display("interrupt test done");
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    {rst, wr, rd, rx_load, mode_fault_event} = 5'h10;
    {slave_select_input, dma_rx_count_write, dma_tx_count_write} = 3'h4;
    {addr, wdata, rx_data} = '0;
    {rcnt, rncnt, tcnt, tncnt} = {4{16'h0004}};
    err_count = 0;
    compares = 0;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    chk(chip_select_lines, 4'hf);
    t_reset;
    t_enable;
    t_tx;
    t_rx;
    t_events;
    t_dma;
    t_irq;
    wrap_up;
  end
  initial begin
    #200000;
    err_count++;
    wrap_up;
  end
endmodule
